// ===== prom_prog_regs.vh
/*
  Constants for the PROM programmer controller: command codes, timing, retry limit.
  Assumes a 25 MHz clock; included by the controller and its pulse timer.
*/
`ifndef PROM_PROG_REGS_VH
`define PROM_PROG_REGS_VH

`define CLK_FREQ_HZ          25000000
`define PULSE_WIDTH_US       100
// divide first: the clock in hertz times the width would overflow a signed 32-bit integer
`define PULSE_CYCLES         (`PULSE_WIDTH_US * (`CLK_FREQ_HZ / 1000000))
`define SETUP_TIME_US        1
`define SETUP_CYCLES         ((`SETUP_TIME_US * `CLK_FREQ_HZ + 999999) / 1000000)
`define ACCESS_DELAY_NS      200
`define ACCESS_CYCLES        ((`ACCESS_DELAY_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define MAX_PULSES           25
`define DATA_WIDTH           16
`define ADDR_WIDTH           16
`define ID_LINE_BIT          9
`define ID_SEL_BIT           0

`define CMD_READ             3'h0
`define CMD_PROGRAM          3'h1
`define CMD_READ_MAKER       3'h2
`define CMD_READ_PART        3'h3

`endif

// ===== prom_wait_timer.v
/*
  Down-counter that times a programmed number of cycles and pulses done at the end.
  Assumes clk, rst_n and ce of the controller; load is a one-cycle pulse.
*/
`include "prom_prog_regs.vh"

module prom_wait_timer #(
  parameter WIDTH = 12
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  // control
  input  wire             load,
  input  wire [WIDTH-1:0] count,
  output reg              done
);

  reg [WIDTH-1:0] remain;
  reg             busy;

  always @(posedge clk) begin
    if (!rst_n) begin
      remain <= {WIDTH{1'b0}};
      busy   <= 1'b0;
      done   <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (load) begin
        remain <= count;
        busy   <= 1'b1;
      end else if (busy) begin
        if (remain <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ===== prom_prog_ctrl.v
/*
  Host-side controller for a 16-bit UV-erasable PROM: reads words, reads the
  identification bytes and programs words with pulse-and-verify.
  Assumes external switches turn supply_prog_en and id_hv_en into the
  elevated program supply, raised main supply and the 12 V id level; the
  data pins are resolved outside from data_oe.
*/
`include "prom_prog_regs.vh"

module prom_prog_ctrl #(
  parameter MAX_PULSES = `MAX_PULSES,
  parameter DW         = `DATA_WIDTH,
  parameter AW         = `ADDR_WIDTH
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst_n,
  input  wire          ce,
  // user command port
  input  wire          cmd_valid,
  input  wire [2:0]    cmd_op,
  input  wire [AW-1:0] cmd_addr,
  input  wire [DW-1:0] cmd_wdata,
  output reg           cmd_ready,
  output reg           rsp_valid,
  output reg  [DW-1:0] rsp_rdata,
  output reg           rsp_fail,
  output reg  [4:0]    rsp_pulses,
  // device pins
  output reg  [AW-1:0] prom_addr,
  output reg           chip_select_n,
  output reg           output_gate_n,
  output reg           program_strobe_n,
  output reg           supply_prog_en,
  output reg           id_hv_en,
  input  wire [DW-1:0] data_in,
  output reg  [DW-1:0] data_out,
  output reg           data_oe
);

  localparam [7:0] S_IDLE    = 8'h01;
  localparam [7:0] S_SETUP   = 8'h02;
  localparam [7:0] S_PULSE   = 8'h04;
  localparam [7:0] S_HOLD    = 8'h08;
  localparam [7:0] S_VERIFY  = 8'h10;
  localparam [7:0] S_READ    = 8'h20;
  localparam [7:0] S_DONE    = 8'h40;
  localparam [7:0] S_RECOVER = 8'h80;

  // timer reload and done pickup add two cycles to every wait; the pulse is
  // trimmed by them so it lasts exactly its count, the minimum waits are not
  localparam integer PULSE_INT  = `PULSE_CYCLES - 2;
  localparam integer SETUP_INT  = `SETUP_CYCLES;
  localparam integer ACCESS_INT = `ACCESS_CYCLES + 1;

  localparam [11:0] PULSE_CNT  = PULSE_INT[11:0];
  localparam [11:0] SETUP_CNT  = SETUP_INT[11:0];
  localparam [11:0] ACCESS_CNT = ACCESS_INT[11:0];

  reg [7:0]    state;
  reg [DW-1:0] sync1;
  reg [DW-1:0] sync2;
  reg [DW-1:0] word;
  reg [4:0]    pulses;
  reg          programming;
  reg          load;
  reg [11:0]   load_count;
  wire         done;

  prom_wait_timer #(
    .WIDTH (12)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .load  (load),
    .count (load_count),
    .done  (done)
  );

  // bits the word asks to be 0 must read 0; ones are don't care
  function verify_ok;
    input [DW-1:0] want;
    input [DW-1:0] got;
    begin
      verify_ok = ((got | want) == want);
    end
  endfunction

  always @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= {DW{1'b0}};
      sync2 <= {DW{1'b0}};
    end else if (ce) begin
      sync1 <= data_in;
      sync2 <= sync1;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state            <= S_IDLE;
      cmd_ready        <= 1'b0;
      rsp_valid        <= 1'b0;
      rsp_rdata        <= {DW{1'b0}};
      rsp_fail         <= 1'b0;
      rsp_pulses       <= 5'h00;
      prom_addr        <= {AW{1'b0}};
      chip_select_n    <= 1'b1;
      output_gate_n    <= 1'b1;
      program_strobe_n <= 1'b1;
      supply_prog_en   <= 1'b0;
      id_hv_en         <= 1'b0;
      data_out         <= {DW{1'b0}};
      data_oe          <= 1'b0;
      word             <= {DW{1'b0}};
      pulses           <= 5'h00;
      programming      <= 1'b0;
      load             <= 1'b0;
      load_count       <= 12'h000;
    end else if (ce) begin
      load      <= 1'b0;
      rsp_valid <= 1'b0;
      cmd_ready <= 1'b0;
      case (state)
        S_IDLE: begin
          // standby between commands keeps every shared output floating
          chip_select_n    <= 1'b1;
          output_gate_n    <= 1'b1;
          program_strobe_n <= 1'b1;
          supply_prog_en   <= 1'b0;
          id_hv_en         <= 1'b0;
          data_oe          <= 1'b0;
          cmd_ready        <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready   <= 1'b0;
            word        <= cmd_wdata;
            pulses      <= 5'h00;
            rsp_fail    <= 1'b0;
            programming <= (cmd_op == `CMD_PROGRAM);
            load        <= 1'b1;
            load_count  <= SETUP_CNT;
            state       <= S_SETUP;
            case (cmd_op)
              `CMD_PROGRAM: begin
                // address, word and supply are set together; the strobe waits for the setup time
                prom_addr      <= cmd_addr;
                data_out       <= cmd_wdata;
                data_oe        <= 1'b1;
                supply_prog_en <= 1'b1;
                chip_select_n  <= 1'b0;
              end
              `CMD_READ_MAKER, `CMD_READ_PART: begin
                // all other address lines low for id access; chip select low, program strobe high
                prom_addr <= {AW{1'b0}};
                prom_addr[`ID_SEL_BIT] <= (cmd_op == `CMD_READ_PART);
                id_hv_en      <= 1'b1;
                chip_select_n <= 1'b0;
              end
              default: begin
                // a fresh address on each read covers a supply sag
                prom_addr     <= cmd_addr;
                chip_select_n <= 1'b0;
              end
            endcase
          end
        end
        S_SETUP: begin
          if (done) begin
            load <= 1'b1;
            if (programming) begin
              // strobe only after address and data have stood the setup time
              program_strobe_n <= 1'b0;
              load_count       <= PULSE_CNT;
              pulses           <= pulses + 5'h01;
              state            <= S_PULSE;
            end else begin
              output_gate_n <= 1'b0;
              load_count    <= ACCESS_CNT;
              state         <= S_READ;
            end
          end
        end
        S_PULSE: begin
          if (done) begin
            program_strobe_n <= 1'b1;
            load             <= 1'b1;
            load_count       <= SETUP_CNT;
            state            <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (done) begin
            // release the bus in the same cycle as the gate opens for the device to drive verify
            data_oe       <= 1'b0;
            output_gate_n <= 1'b0;
            load          <= 1'b1;
            load_count    <= ACCESS_CNT;
            state         <= S_VERIFY;
          end
        end
        S_VERIFY: begin
          if (done) begin
            output_gate_n <= 1'b1;
            if (verify_ok(word, sync2)) begin
              rsp_rdata <= sync2;
              state     <= S_DONE;
            end else if (pulses >= MAX_PULSES[4:0]) begin
              rsp_rdata <= sync2;
              rsp_fail  <= 1'b1;
              state     <= S_DONE;
            end else begin
              load       <= 1'b1;
              load_count <= SETUP_CNT;
              state      <= S_RECOVER;
            end
          end
        end
        S_RECOVER: begin
          // gate high again before driving the word back
          data_oe <= 1'b1;
          if (done) begin
            program_strobe_n <= 1'b0;
            pulses           <= pulses + 5'h01;
            load             <= 1'b1;
            load_count       <= PULSE_CNT;
            state            <= S_PULSE;
          end
        end
        S_READ: begin
          if (done) begin
            // id byte lives in the low byte; the high byte is dropped
            if (id_hv_en) begin
              rsp_rdata <= {{(DW-8){1'b0}}, sync2[7:0]};
            end else begin
              rsp_rdata <= sync2;
            end
            output_gate_n <= 1'b1;
            state         <= S_DONE;
          end
        end
        S_DONE: begin
          chip_select_n  <= 1'b1;
          supply_prog_en <= 1'b0;
          id_hv_en       <= 1'b0;
          data_oe        <= 1'b0;
          rsp_pulses     <= pulses;
          rsp_valid      <= 1'b1;
          state          <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== prom_checker.sv
/*
  Pin-level checker for the PROM controller.
  Assumes ce is held high, so every clock edge advances the controller.
*/
`include "prom_prog_regs.vh"
module prom_checker #(parameter MAX_PULSES = 25, parameter DW = 16, parameter AW = 16) (
  // clock and reset
  input wire          clk,
  input wire          rst_n,
  // user side
  input wire          cmd_valid,
  input wire          cmd_ready,
  input wire          rsp_valid,
  input wire          rsp_fail,
  input wire [4:0]    rsp_pulses,
  // device pins
  input wire [AW-1:0] prom_addr,
  input wire          chip_select_n,
  input wire          output_gate_n,
  input wire          program_strobe_n,
  input wire          supply_prog_en,
  input wire          id_hv_en,
  input wire [DW-1:0] data_out,
  input wire          data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] low_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // counts edges the strobe has been seen low
  always @(posedge clk) begin
    if (!rst_n || program_strobe_n)
      low_cnt <= 12'h000;
    else
      low_cnt <= low_cnt + 12'h001;
  end
  strobe_width_a: assert property ($rose(program_strobe_n) |-> low_cnt == `PULSE_CYCLES)
    else $error("strobe pulse length wrong");
  strobe_static_a: assert property (!program_strobe_n |-> low_cnt < `PULSE_CYCLES)
    else $error("strobe held low too long");
  strobe_mode_a: assert property (!program_strobe_n |-> supply_prog_en && !chip_select_n && output_gate_n && data_oe)
    else $error("strobe outside program mode");
  strobe_stable_a: assert property (!program_strobe_n |-> $stable(prom_addr) && $stable(data_out))
    else $error("address or data moved under strobe");
  data_hold_a: assert property ($rose(program_strobe_n) |-> (data_oe && output_gate_n)[*8])
    else $error("data released too early");
  gate_contention_a: assert property (!output_gate_n |-> !data_oe && !chip_select_n)
    else $error("gate low while host drives");
  id_lines_a: assert property (id_hv_en |-> (prom_addr & 16'hFDFE) == 16'h0000 && !supply_prog_en)
    else $error("id access with other lines high");
  idle_supply_a: assert property (cmd_ready |-> !supply_prog_en && !id_hv_en)
    else $error("raised supply while idle");
  fail_count_a: assert property (rsp_valid && rsp_fail |-> rsp_pulses == MAX_PULSES)
    else $error("fail before pulse limit");
  pulse_limit_a: assert property (rsp_valid |-> (rsp_pulses <= MAX_PULSES && rsp_pulses != 5'h00) == $past(supply_prog_en))
    else $error("pulse count out of range");
  rsp_single_a: assert property (rsp_valid |=> !rsp_valid ##[0:2] cmd_ready)
    else $error("response not single or ready late");
  take_busy_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready && !rsp_valid)
    else $error("ready stayed up after take");
endmodule
bind prom_prog_ctrl prom_checker #(.MAX_PULSES(MAX_PULSES), .DW(DW), .AW(AW)) chk (
  .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
  .rsp_fail(rsp_fail), .rsp_pulses(rsp_pulses), .prom_addr(prom_addr), .chip_select_n(chip_select_n),
  .output_gate_n(output_gate_n), .program_strobe_n(program_strobe_n), .supply_prog_en(supply_prog_en),
  .id_hv_en(id_hv_en), .data_out(data_out), .data_oe(data_oe));

// ===== prom_model.sv
/*
  Behavioural 16-bit UV PROM facing the controller; resolves the data pins.
  Assumes a word only programs after need_pulses pulses; above 25 it never does.
*/
module prom_model #(parameter [7:0] MAKER_ID = 8'h5A, parameter [7:0] PART_ID = 8'hC3) (
  // scenario control
  input wire  [4:0]  need_pulses,
  // device pins
  input wire  [15:0] prom_addr,
  input wire         chip_select_n,
  input wire         output_gate_n,
  input wire         program_strobe_n,
  input wire         supply_prog_en,
  input wire         id_hv_en,
  input wire  [15:0] data_out,
  input wire         data_oe,
  output logic [15:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:15];
  logic [15:0] last;
  logic [4:0]  hits;
  // data shows at once; the controller's access wait covers the real delay
  wire reading = !chip_select_n && !output_gate_n && program_strobe_n;
  wire id_ok   = id_hv_en && !supply_prog_en && (prom_addr & 16'hFDFE) == 16'h0000;
  wire [15:0] word = id_ok ? {8'h00, prom_addr[0] ? PART_ID : MAKER_ID} : mem[prom_addr[3:0]];
  initial begin
    for (int i = 0; i < 16; i++)
      mem[i] = 16'hFFFF;
    last = 16'h0000;
    hits = 5'h00;
  end
  always @(posedge supply_prog_en)
    hits = 5'h00;
  // deselected parts ignore the strobe
  always @(negedge program_strobe_n) begin
    if (supply_prog_en && !chip_select_n && output_gate_n) begin
      hits = hits + 5'h01;
      if (hits == need_pulses)
        mem[prom_addr[3:0]] = mem[prom_addr[3:0]] & data_out;
    end
  end
  // a floating bus shows the inverse of its last value, never a stale match
  always @* begin
    if (data_oe)
      data_in = data_out;
    else if (reading)
      data_in = word;
    else
      data_in = ~last;
  end
  always @(data_in)
    if (data_oe || reading)
      last = data_in;
endmodule

// ===== testbench.sv
/*
  Self-checking bench: controller against the behavioural PROM.
  Assumes the shared constants header; ce stays high.
*/
`include "prom_prog_regs.vh"
`define CHECK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [7:0] MAKER_ID = 8'h5A; // arbitrary value
  localparam [7:0] PART_ID  = 8'hC3; // arbitrary value
  logic        clk, rst_n, cmd_valid;
  logic [2:0]  cmd_op;
  logic [15:0] cmd_addr, cmd_wdata, img [0:15];
  logic [4:0]  need_pulses;
  logic [31:0] seed = 32'h4869;
  logic [21:0] exp_q [$];
  logic [21:0] note;
  int          errors = 0;
  int          samples_checked = 0;
  wire         cmd_ready, rsp_valid, rsp_fail, chip_select_n, output_gate_n, program_strobe_n;
  wire         supply_prog_en, id_hv_en, data_oe;
  wire [15:0]  rsp_rdata, prom_addr, data_in, data_out;
  wire [4:0]   rsp_pulses;
  prom_prog_ctrl dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_fail(rsp_fail), .rsp_pulses(rsp_pulses), .prom_addr(prom_addr),
    .chip_select_n(chip_select_n), .output_gate_n(output_gate_n), .program_strobe_n(program_strobe_n),
    .supply_prog_en(supply_prog_en), .id_hv_en(id_hv_en), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe));
  prom_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) prom (.need_pulses(need_pulses),
    .prom_addr(prom_addr), .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
    .program_strobe_n(program_strobe_n), .supply_prog_en(supply_prog_en), .id_hv_en(id_hv_en),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task close_out;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // notes the expected answer, presents the command, then waits for its answer
  task automatic run(input logic [2:0] op, input logic [15:0] addr, input logic [15:0] wd, input logic [4:0] need);
    logic [15:0] old;
    logic        miss;
    logic [4:0]  p;
    old  = img[addr[3:0]];
    miss = (old & ~wd) != 16'h0000 && need > 5'h19;
    p    = (old & ~wd) == 16'h0000 ? 5'h01 : (miss ? 5'h19 : need);
    if (op == `CMD_PROGRAM) begin
      if (!miss)
        img[addr[3:0]] = old & wd;
      exp_q.push_back({miss, p, miss ? old : old & wd});
    end else
      exp_q.push_back({1'b0, 5'h00, op == `CMD_READ ? old : {8'h00, op == `CMD_READ_PART ? PART_ID : MAKER_ID}});
    @(negedge clk);
    cmd_valid   = 1'b1;
    cmd_op      = op;
    cmd_addr    = addr;
    cmd_wdata   = wd;
    need_pulses = need;
    @(posedge clk);
    while (cmd_ready !== 1'b1)
      @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    while (exp_q.size() != 0)
      @(negedge clk);
  endtask
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) begin
      `CHECK("rsp_noted", 1'b1, exp_q.size() != 0)
      note = exp_q.pop_front();
      `CHECK("rsp_rdata", note[15:0], rsp_rdata)
      `CHECK("rsp_pulses", note[20:16], rsp_pulses)
      `CHECK("rsp_fail", note[21], rsp_fail)
    end
  end
  initial begin
    #(95000 * 40);
    errors++;
    close_out;
  end
  initial begin
    for (int i = 0; i < 16; i++)
      img[i] = 16'hFFFF;
    rst_n       = 1'b0;
    cmd_valid   = 1'b0;
    cmd_op      = 3'h0;
    cmd_addr    = 16'h0000;
    cmd_wdata   = 16'h0000;
    need_pulses = 5'h01;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    run(`CMD_READ, {12'(rnd() >> 20), 4'h3}, 16'h0000, 5'h01);
    run(`CMD_PROGRAM, {12'(rnd() >> 20), 4'h3}, 16'(rnd() >> 16), 5'h01);
    run(`CMD_PROGRAM, {12'(rnd() >> 20), 4'h3}, 16'(rnd() >> 16), 5'h03);
    run(`CMD_READ, {12'(rnd() >> 20), 4'h3}, 16'h0000, 5'h01);
    run(`CMD_READ_MAKER, 16'(rnd() >> 16), 16'h0000, 5'h01);
    run(`CMD_READ_PART, 16'(rnd() >> 16), 16'h0000, 5'h01);
    run(`CMD_PROGRAM, 16'h0005, 16'(rnd() >> 16) & 16'hFFFE, 5'h1F);
    run(`CMD_READ, 16'h0005, 16'h0000, 5'h01);
    close_out;
  end
endmodule
